// [core/mfd_pkg.sv]
package mfd_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ------------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFS       = 4'h0;
  localparam logic [3:0]  STAT_OFS       = 4'h4;
  localparam logic [3:0]  IRQ_STAT_OFS   = 4'h8;
  localparam logic [3:0]  IRQ_MASK_OFS   = 4'hc;

  // Control fields
  localparam int          CTRL_REL_LSB   = 0;
  localparam int          CTRL_REL_W     = 4;
  localparam int          CTRL_HIGH_BIT  = 4;
  localparam int          CTRL_WIDE_BIT  = 5;
  localparam logic [3:0]  REL_RESET      = 4'h6;
  localparam logic        HIGH_RESET     = 1'b1;
  localparam logic        WIDE_RESET     = 1'b1;

  // Status fields
  localparam int          STAT_CNT_W     = 16;
  localparam int          STAT_OP_LSB    = 16;

  // Interrupt status / mask bits
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_RESV_BIT   = 0;
  localparam int          IRQ_ZERO_BIT   = 1;
  localparam int          IRQ_ODD_BIT    = 2;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

  // Release thresholds
  localparam logic [3:0]  REL_HIGH_WORD  = 4'h2;
  localparam logic [3:0]  REL_SIX        = 4'h6;

  // ------------------------------------------------------------------
  // Operations and carriers
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SYS_WORD   = 4'b0000,
    OP_SYS_HIGH   = 4'b0001,
    OP_FLOAT_LOW  = 4'b0010,
    OP_FLOAT_HIGH = 4'b0011,
    OP_COP2_WORD  = 4'b0100,
    OP_COP2_HIGH  = 4'b0101,
    OP_UPPER_PROD = 4'b0110,
    OP_BOTTOM_PROD= 4'b0111,
    OP_FLOAT_MOVE = 4'b1000
  } mfd_op_t;

  typedef struct packed {
    mfd_op_t     op;
    logic [4:0]  targetIndex;
    logic [4:0]  sysRegNum;
    logic [2:0]  sysRegSel;
    logic [4:0]  sourceFloatIndex;
    logic [4:0]  destFloatIndex;
    logic [7:0]  cop2Code;
    logic        pairedFmt;
  } mfd_req_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [31:0] data;
  } mfd_gpr_wr_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [63:0] data;
  } mfd_fpr_wr_t;

endpackage

// [core/mfd_datapath.sv]
`timescale 1ns/1ps
module mfd_datapath
  import mfd_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // Avalon-MM register slave
  input  wire logic [3:0]        avsAddress,
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire logic [31:0]       avsWriteData,
  input  wire logic [3:0]        avsByteEnable,
  output logic      [31:0]       avsReadData,
  output logic                   avsWaitRequest,
  // Instruction request from decode
  input  wire logic              reqValid,
  input  wire mfd_pkg::mfd_req_t reqIn,
  output logic                   reqReady,
  // System-control register array port
  output logic      [4:0]        sysRegNum,
  output logic      [2:0]        sysRegSel,
  input  wire logic [63:0]       sysRegData,
  input  wire logic              sysRegImplemented,
  input  wire logic              sysRegExtended,
  // Float register file port
  output logic      [4:0]        floatRdIndex,
  input  wire logic [63:0]       floatRdData,
  output mfd_pkg::mfd_fpr_wr_t   floatWr,
  // Coprocessor 2 register array port
  output logic      [7:0]        cop2Code,
  input  wire logic [63:0]       cop2Data,
  input  wire logic              cop2Exists,
  input  wire logic              cop2Wide,
  // Multiply result registers
  input  wire logic [31:0]       multiplyUpperWord,
  input  wire logic [31:0]       multiplyBottomWord,
  // Results to writeback
  output mfd_pkg::mfd_gpr_wr_t   gprWr,
  output logic                   reservedInstr,
  output logic                   irq
);
  import mfd_pkg::*;

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [3:0]            release_q;
  logic                  highSupported_q;
  logic                  wideFloatMode_q;
  logic [STAT_CNT_W-1:0] moveCount_q;
  mfd_op_t               lastOp_q;
  logic [IRQ_W-1:0]      irqStatus_q;
  logic [IRQ_W-1:0]      irqMask_q;
  logic                  ack_q;
  logic [31:0]           readData_q;
  mfd_gpr_wr_t           gprWr_q;
  mfd_fpr_wr_t           floatWr_q;
  logic                  reservedInstr_q;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire logic busReq     = avsRead | avsWrite;
  wire logic busDone    = busReq & ack_q;
  wire logic hitCtrl    = (avsAddress == CTRL_OFS);
  wire logic hitStat    = (avsAddress == STAT_OFS);
  wire logic hitIrqStat = (avsAddress == IRQ_STAT_OFS);
  wire logic hitIrqMask = (avsAddress == IRQ_MASK_OFS);
  wire logic wrCtrl     = avsWrite & busDone & hitCtrl & avsByteEnable[0];
  wire logic wrMask     = avsWrite & busDone & hitIrqMask & avsByteEnable[0];
  wire logic rdClear    = avsRead & busDone & hitIrqStat;

  // One wait cycle per access; read data captured in that cycle
  assign avsWaitRequest = busReq & ~ack_q;
  assign avsReadData    = readData_q;

  // Register read mux; unmapped offsets read zero
  logic [31:0] readMux;
  assign readMux = hitCtrl    ? {26'h0, wideFloatMode_q, highSupported_q, release_q} :
                   hitStat    ? {12'h0, lastOp_q, moveCount_q} :
                   hitIrqStat ? {29'h0, irqStatus_q} :
                   hitIrqMask ? {29'h0, irqMask_q} : 32'h0;

  // ------------------------------------------------------------------
  // Datapath decode
  // ------------------------------------------------------------------
  // The block answers every cycle; no stall toward decode
  assign reqReady     = 1'b1;
  assign sysRegNum    = reqIn.sysRegNum;
  assign sysRegSel    = reqIn.sysRegSel;
  assign floatRdIndex = reqIn.sourceFloatIndex;
  assign cop2Code     = reqIn.cop2Code;

  wire logic relAtLeastTwo = (release_q >= REL_HIGH_WORD);
  wire logic relAtLeastSix = (release_q >= REL_SIX);
  wire logic isSysWord     = (reqIn.op == OP_SYS_WORD);
  wire logic isSysHigh     = (reqIn.op == OP_SYS_HIGH);
  wire logic isFloatLow    = (reqIn.op == OP_FLOAT_LOW);
  wire logic isFloatHigh   = (reqIn.op == OP_FLOAT_HIGH);
  wire logic isCop2Word    = (reqIn.op == OP_COP2_WORD);
  wire logic isCop2High    = (reqIn.op == OP_COP2_HIGH);
  wire logic isUpper       = (reqIn.op == OP_UPPER_PROD);
  wire logic isBottom      = (reqIn.op == OP_BOTTOM_PROD);
  wire logic isMove        = (reqIn.op == OP_FLOAT_MOVE);
  wire logic isLegalOp     = isSysWord | isSysHigh | isFloatLow | isFloatHigh |
                             isCop2Word | isCop2High | isUpper | isBottom | isMove;

  // Narrow float mode with an odd index has no defined high word
  wire logic oddNarrow = ~wideFloatMode_q & reqIn.sourceFloatIndex[0];

  // Reserved-instruction conditions
  // high access gate
  wire logic resvHigh = isSysHigh & ~highSupported_q;
  wire logic resvEarly = (isFloatHigh | isCop2High) & ~relAtLeastTwo;
  wire logic resvProd = (isUpper | isBottom) & relAtLeastSix;
  // Paired move was withdrawn together with the product copies
  wire logic resvPaired = isMove & reqIn.pairedFmt & relAtLeastSix;
  wire logic resvAny = ~isLegalOp | resvHigh | resvEarly | resvProd | resvPaired;

  // Missing register cases; zero is returned whenever the operation is not reserved
  // zero unless reserved (float and cop2 high words below release 2, system high word without high support)
  wire logic sysMissing  = isSysWord & ~sysRegImplemented;
  wire logic highMissing = isSysHigh & ~(sysRegImplemented & sysRegExtended);
  wire logic cop2Missing = (isCop2Word & ~cop2Exists) |
                           (isCop2High & ~(cop2Exists & cop2Wide));
  wire logic zeroUsed    = sysMissing | highMissing | cop2Missing |
                           (isFloatHigh & oddNarrow);

  // Result selection
  logic [31:0] sysWordVal;
  logic [31:0] sysHighVal;
  logic [31:0] floatHighVal;
  logic [31:0] cop2WordVal;
  logic [31:0] cop2HighVal;
  logic [31:0] gprResult;
  assign sysWordVal = sysRegImplemented ? sysRegData[31:0] : 32'h0;
  assign sysHighVal = (sysRegImplemented & sysRegExtended) ? sysRegData[63:32] : 32'h0;
  assign floatHighVal = oddNarrow ? 32'h0 : floatRdData[63:32];
  assign cop2WordVal = cop2Exists ? cop2Data[31:0] : 32'h0;
  assign cop2HighVal = (cop2Exists & cop2Wide) ? cop2Data[63:32] : 32'h0;
  assign gprResult = isSysWord   ? sysWordVal :
                     isSysHigh   ? sysHighVal :
                     isFloatLow  ? floatRdData[31:0] :
                     isFloatHigh ? floatHighVal :
                     isCop2Word  ? cop2WordVal :
                     isCop2High  ? cop2HighVal :
                     isUpper     ? multiplyUpperWord :
                     isBottom    ? multiplyBottomWord : 32'h0;

  wire logic fire    = reqValid & reqReady;
  wire logic gprFire = fire & ~resvAny & ~isMove;
  wire logic fprFire = fire & ~resvAny & isMove;

  // Events for the interrupt status register
  logic [IRQ_W-1:0] irqEvent;
  assign irqEvent[IRQ_RESV_BIT] = fire & resvAny;
  assign irqEvent[IRQ_ZERO_BIT] = fire & ~resvAny & (sysMissing | highMissing | cop2Missing);
  assign irqEvent[IRQ_ODD_BIT]  = fire & ~resvAny & isFloatHigh & oddNarrow;

  // ------------------------------------------------------------------
  // Bus slave and control registers
  // ------------------------------------------------------------------
  // Ack toggles so back-to-back accesses each see one wait cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_q      <= 1'b0;
      readData_q <= 32'h0;
    end else begin
      ack_q      <= busReq & ~ack_q;
      readData_q <= readMux;
    end
  end

  // Control register; steers release gating and float mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      release_q       <= REL_RESET;
      highSupported_q <= HIGH_RESET;
      wideFloatMode_q <= WIDE_RESET;
    end else if (wrCtrl) begin
      release_q       <= avsWriteData[CTRL_REL_LSB +: CTRL_REL_W];
      highSupported_q <= avsWriteData[CTRL_HIGH_BIT];
      wideFloatMode_q <= avsWriteData[CTRL_WIDE_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqMask_q <= IRQ_MASK_RESET;
    end else if (wrMask) begin
      irqMask_q <= avsWriteData[IRQ_W-1:0];
    end
  end

  // Sticky status; a new event wins over the read clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStatus_q <= '0;
    end else begin
      irqStatus_q <= (rdClear ? '0 : irqStatus_q) | irqEvent;
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  // Completed-move counter and last operation, visible in status
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      moveCount_q <= '0;
      lastOp_q    <= OP_SYS_WORD;
    end else if (fire) begin
      moveCount_q <= moveCount_q + STAT_CNT_W'(gprFire | fprFire);
      lastOp_q    <= reqIn.op;
    end
  end

  // ------------------------------------------------------------------
  // Result stage
  // ------------------------------------------------------------------
  // Operands are sampled in the issue cycle, so later writers of the
  // multiply registers cannot disturb a result already captured.
  // sample at issue
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gprWr_q         <= '0;
      floatWr_q       <= '0;
      reservedInstr_q <= 1'b0;
    end else begin
      gprWr_q.valid   <= gprFire;
      gprWr_q.index   <= reqIn.targetIndex;
      gprWr_q.data    <= gprResult;
      floatWr_q.valid <= fprFire;
      floatWr_q.index <= reqIn.destFloatIndex;
      floatWr_q.data  <= floatRdData;
      reservedInstr_q <= fire & resvAny;
    end
  end

  assign gprWr         = gprWr_q;
  assign floatWr       = floatWr_q;
  assign reservedInstr = reservedInstr_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence issueSysHigh;
    reqValid && reqIn.op == OP_SYS_HIGH;
  endsequence

  sequence refusedWrite;
    reservedInstr && !gprWr.valid;
  endsequence

  sys_word_read_a: assert property (
    reqValid && reqIn.op == OP_SYS_WORD && sysRegImplemented |=>
      gprWr.valid && gprWr.data == $past(sysRegData[31:0]) &&
      gprWr.index == $past(reqIn.targetIndex))
    else $error("system word read value wrong");

  sys_missing_zero_a: assert property (
    reqValid && reqIn.op == OP_SYS_WORD && !sysRegImplemented |=>
      gprWr.valid && gprWr.data == 32'h0 && irqStatus_q[IRQ_ZERO_BIT])
    else $error("missing system register not zero");

  float_low_a: assert property (
    reqValid && reqIn.op == OP_FLOAT_LOW |=>
      gprWr.valid && gprWr.data == $past(floatRdData[31:0]))
    else $error("low float word wrong");

  cop2_word_a: assert property (
    reqValid && reqIn.op == OP_COP2_WORD && cop2Exists |=>
      gprWr.data == $past(cop2Data[31:0]))
    else $error("cop2 word wrong");

  sys_high_read_a: assert property (
    issueSysHigh and (highSupported_q && sysRegImplemented && sysRegExtended) |=>
      gprWr.valid && gprWr.data == $past(sysRegData[63:32]))
    else $error("system high read wrong");

  high_unsupported_a: assert property (
    issueSysHigh and (!highSupported_q) |=> refusedWrite ##1 !reservedInstr || reqValid)
    else $error("unsupported high read not refused");

  high_unextended_a: assert property (
    issueSysHigh and (highSupported_q && !sysRegExtended) |=>
      gprWr.valid && gprWr.data == 32'h0)
    else $error("unextended high read not zero");

  float_high_a: assert property (
    reqValid && reqIn.op == OP_FLOAT_HIGH && relAtLeastTwo && !oddNarrow |=>
      gprWr.data == $past(floatRdData[63:32]))
    else $error("high float word wrong");

  early_high_a: assert property (
    reqValid && (reqIn.op == OP_FLOAT_HIGH || reqIn.op == OP_COP2_HIGH) &&
      release_q < REL_HIGH_WORD |=> refusedWrite)
    else $error("early high read not reserved");

  product_copy_a: assert property (
    reqValid && reqIn.op == OP_UPPER_PROD && !relAtLeastSix |=>
      !reservedInstr && gprWr.data == $past(multiplyUpperWord))
    else $error("upper product copy wrong");

  product_removed_a: assert property (
    reqValid && reqIn.op == OP_BOTTOM_PROD && relAtLeastSix |=> refusedWrite)
    else $error("bottom product copy not reserved");

  float_move_a: assert property (
    reqValid && reqIn.op == OP_FLOAT_MOVE && !resvAny |=>
      floatWr.valid && floatWr.data == $past(floatRdData) && !gprWr.valid)
    else $error("float move wrong");

endmodule // mfd_datapath

// [testbench/mfd_pipe_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Register arrays seen by the datapath, answering in the same cycle
// ------------------------------------------------------------------
module mfd_pipe_model (
  // Selects from the datapath
  input  wire logic [4:0]  sysRegNum,
  input  wire logic [2:0]  sysRegSel,
  input  wire logic [4:0]  floatRdIndex,
  input  wire logic [7:0]  cop2Code,
  // Same-cycle answers
  output logic      [63:0] sysRegData,
  output logic             sysRegImplemented,
  output logic             sysRegExtended,
  output logic      [63:0] floatRdData,
  output logic      [63:0] cop2Data,
  output logic             cop2Exists,
  output logic             cop2Wide
);
  // Four different quarters, so a swapped or shifted word shows up
  function automatic logic [63:0] mix(input logic [15:0] k);
    return {k, ~k, k ^ 16'ha5c3, k + 16'h1357};
  endfunction

  assign sysRegData        = mix({8'h00, sysRegNum, sysRegSel});
  assign sysRegImplemented = sysRegNum != 5'h1f;  // Top number is a hole
  assign sysRegExtended    = !sysRegNum[4];       // Upper half of the map is narrow
  assign floatRdData       = mix({11'h400, floatRdIndex});
  assign cop2Data          = mix({8'h80, cop2Code});
  assign cop2Exists        = cop2Code != 8'hff;
  assign cop2Wide          = !cop2Code[7];
endmodule // mfd_pipe_model

// [testbench/test_register_move_from_datapath.sv]
`timescale 1ns/1ps
module test_register_move_from_datapath;
  import mfd_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        sys_clk, reset, avsRead, avsWrite, avsWaitRequest, reqValid, reqReady;
  logic [3:0]  avsAddress, avsByteEnable, rel;
  logic [31:0] avsWriteData, avsReadData, mulUp, mulBot, seed, rd;
  logic [4:0]  sysRegNum, floatRdIndex;
  logic [2:0]  sysRegSel;
  logic [7:0]  cop2Code;
  logic [63:0] sysRegData, floatRdData, cop2Data;
  logic        sysRegImplemented, sysRegExtended, cop2Exists, cop2Wide;
  logic        reservedInstr, irq, hs, wd;
  mfd_req_t    reqIn, r;
  mfd_gpr_wr_t gprWr;
  mfd_fpr_wr_t floatWr;
  int          errors, total_checks, moves, cyc;
  logic [5:0]  cfg [4] = '{6'h36, 6'h11, 6'h03, 6'h32};

  mfd_datapath dut (.sys_clk(sys_clk), .reset(reset), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .reqValid(reqValid), .reqIn(reqIn),
    .reqReady(reqReady), .sysRegNum(sysRegNum), .sysRegSel(sysRegSel),
    .sysRegData(sysRegData), .sysRegImplemented(sysRegImplemented),
    .sysRegExtended(sysRegExtended), .floatRdIndex(floatRdIndex),
    .floatRdData(floatRdData), .floatWr(floatWr), .cop2Code(cop2Code),
    .cop2Data(cop2Data), .cop2Exists(cop2Exists), .cop2Wide(cop2Wide),
    .multiplyUpperWord(mulUp), .multiplyBottomWord(mulBot), .gprWr(gprWr),
    .reservedInstr(reservedInstr), .irq(irq));
  mfd_pipe_model pm (.sysRegNum(sysRegNum), .sysRegSel(sysRegSel),
    .floatRdIndex(floatRdIndex), .cop2Code(cop2Code), .sysRegData(sysRegData),
    .sysRegImplemented(sysRegImplemented), .sysRegExtended(sysRegExtended),
    .floatRdData(floatRdData), .cop2Data(cop2Data), .cop2Exists(cop2Exists),
    .cop2Wide(cop2Wide));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [63:0] mix(input logic [15:0] k);
    return {k, ~k, k ^ 16'ha5c3, k + 16'h1357};
  endfunction
  // Kind 0 general write, 1 float write, 2 refused
  function automatic void predict(input mfd_req_t q, input logic [31:0] u, b,
                                  output logic [1:0] kind, output logic [63:0] v);
    logic [63:0] s, f, c;
    s = mix({8'h00, q.sysRegNum, q.sysRegSel});
    f = mix({11'h400, q.sourceFloatIndex});
    c = mix({8'h80, q.cop2Code});
    kind = 2'd0;
    v = 64'h0;
    case (q.op)
      OP_SYS_WORD:    v = {32'h0, s[31:0] & {32{q.sysRegNum != 5'h1f}}};
      OP_SYS_HIGH:    begin
        v = {32'h0, s[63:32] & {32{!q.sysRegNum[4]}}};
        kind = hs ? 2'd0 : 2'd2;
      end
      OP_FLOAT_LOW:   v = {32'h0, f[31:0]};
      // Narrow mode with an odd index reads zero
      OP_FLOAT_HIGH:  begin
        v = {32'h0, f[63:32] & {32{wd | !q.sourceFloatIndex[0]}}};
        kind = (rel < REL_HIGH_WORD) ? 2'd2 : 2'd0;
      end
      OP_COP2_WORD:   v = {32'h0, c[31:0] & {32{q.cop2Code != 8'hff}}};
      OP_COP2_HIGH:   begin
        v = {32'h0, c[63:32] & {32{!q.cop2Code[7]}}};
        kind = (rel < REL_HIGH_WORD) ? 2'd2 : 2'd0;
      end
      OP_UPPER_PROD:  begin v = {32'h0, u}; kind = (rel >= REL_SIX) ? 2'd2 : 2'd0; end
      OP_BOTTOM_PROD: begin v = {32'h0, b}; kind = (rel >= REL_SIX) ? 2'd2 : 2'd0; end
      OP_FLOAT_MOVE:  kind = (q.pairedFmt && rel >= REL_SIX) ? 2'd2 : 2'd1;
      default:        kind = 2'd2;
    endcase
    if (q.op == OP_FLOAT_MOVE) v = f;
  endfunction

  task automatic check_val(input string what, input logic [63:0] expv, input logic [63:0] seen);
    total_checks++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Request held until waitrequest is seen low; data taken in that cycle
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wdat);
    int n;
    n = 0;
    @(posedge sys_clk);
    avsRead      <= ~wr;
    avsWrite     <= wr;
    avsAddress   <= adr;
    avsWriteData <= wdat;
    do begin
      @(negedge sys_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rd = avsReadData;
    if (n >= 50) check_val("bus answer", 64'h0, 64'h1);
    @(posedge sys_clk);
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic issue(input mfd_req_t q);
    logic [31:0] u, b;
    logic [1:0]  kind;
    logic [63:0] v;
    u = rnd();
    b = rnd();
    predict(q, u, b, kind, v);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqIn    <= q;
    mulUp    <= u;
    mulBot   <= b;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    mulUp    <= ~u;
    #1;
    check_val("reserved", {63'h0, kind == 2'd2}, {63'h0, reservedInstr});
    check_val("gpr valid", {63'h0, kind == 2'd0}, {63'h0, gprWr.valid});
    check_val("float valid", {63'h0, kind == 2'd1}, {63'h0, floatWr.valid});
    if (kind == 2'd0) begin
      check_val("gpr index", {59'h0, q.targetIndex}, {59'h0, gprWr.index});
      check_val("gpr data", v, {32'h0, gprWr.data});
    end
    if (kind == 2'd1) begin
      check_val("float index", {59'h0, q.destFloatIndex}, {59'h0, floatWr.index});
      check_val("float data", v, floatWr.data);
    end
    if (kind != 2'd2) moves++;
  endtask

  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Clock, timeout, sequence
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Whole run is a few hundred cycles; generous ceiling
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    {reset, reqValid, avsRead, avsWrite} = 4'h8;
    {avsAddress, avsWriteData, mulUp, mulBot} = '0;
    avsByteEnable = 4'hf;
    reqIn = '0;
    seed = 32'hcecb;
    {errors, total_checks, moves, cyc} = '0;
    {wd, hs, rel} = {WIDE_RESET, HIGH_RESET, REL_RESET};
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    bus(1'b0, CTRL_OFS, 32'h0);
    check_val("ctrl reset", {58'h0, WIDE_RESET, HIGH_RESET, REL_RESET}, {58'h0, rd[5:0]});
    bus(1'b0, IRQ_MASK_OFS, 32'h0);
    check_val("mask reset", {61'h0, IRQ_MASK_RESET}, {61'h0, rd[2:0]});
    bus(1'b0, 4'h2, 32'h0);
    check_val("unmapped", 64'h0, {32'h0, rd});
    avsByteEnable <= 4'h0;
    bus(1'b1, CTRL_OFS, 32'h0);
    avsByteEnable <= 4'hf;
    bus(1'b0, CTRL_OFS, 32'h0);
    check_val("ctrl lane off", 64'h36, {58'h0, rd[5:0]});
    for (int c = 0; c < 4; c++) begin
      {wd, hs, rel} = cfg[c];
      bus(1'b1, CTRL_OFS, {26'h0, cfg[c]});
      bus(1'b0, CTRL_OFS, 32'h0);
      check_val("ctrl", {58'h0, cfg[c]}, {58'h0, rd[5:0]});
      for (int i = 0; i < 64; i++) begin
        r = {rnd(), rnd()};
        r.op = mfd_op_t'(4'(i >> 2));
        if (i % 4 == 0) {r.sysRegNum, r.cop2Code} = 13'h1fff;
        if (i % 4 == 1) r.sourceFloatIndex[0] = 1'b1;
        if (r.sysRegNum >= 5'd24) r.sysRegSel = 3'h0;
        issue(r);
      end
    end
    // Interrupt raise, clear by read, mask
    bus(1'b1, IRQ_MASK_OFS, 32'h7);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    r = '0;
    r.op = mfd_op_t'(4'hf);
    issue(r);
    repeat (2) @(posedge sys_clk);
    #1 check_val("irq raised", 64'h1, {63'h0, irq});
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check_val("irq status", 64'h1, {61'h0, rd[2:0]});
    #1 check_val("irq cleared", 64'h0, {63'h0, irq});
    {wd, hs, rel} = 6'h12;
    bus(1'b1, CTRL_OFS, 32'h12);
    r.op = OP_FLOAT_HIGH;
    r.sourceFloatIndex = 5'h3;
    issue(r);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check_val("odd narrow status", 64'h4, {61'h0, rd[2:0]});
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    r.op = mfd_op_t'(4'h9);
    issue(r);
    repeat (2) @(posedge sys_clk);
    #1 check_val("irq masked", 64'h0, {63'h0, irq});
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check_val("masked status", 64'h1, {61'h0, rd[2:0]});
    bus(1'b0, STAT_OFS, 32'h0);
    check_val("move count", moves, {48'h0, rd[15:0]});
    complete_run();
  end
endmodule // test_register_move_from_datapath
